// *** hw/cpps_pkg.sv ***
/*
 * Package for the core program-state block: data-space map, widths,
 * vectors, stack depth, mode and program-counter source encodings,
 * and the packed command carriers.
 * Assumes a single core clock domain and an external sequencer.
 */
package cpps_pkg;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int unsigned CPPS_DATA_W  = 8;
    localparam int unsigned CPPS_PC_W    = 12;
    localparam int unsigned CPPS_STACK_N = 6;
    localparam int unsigned CPPS_DEPTH_W = 3;
    localparam int unsigned CPPS_PAGE_W  = 5;

    // ------------------------------------------------------------
    // data-space locations
    // ------------------------------------------------------------
    localparam logic [7:0] CPPS_ADDR_PTR_ONE   = 8'h80;
    localparam logic [7:0] CPPS_ADDR_PTR_TWO   = 8'h81;
    localparam logic [7:0] CPPS_ADDR_SHORT_ONE = 8'h82;
    localparam logic [7:0] CPPS_ADDR_SHORT_TWO = 8'h83;
    localparam logic [7:0] CPPS_ADDR_PAGE_SEL  = 8'hCA;
    localparam logic [7:0] CPPS_ADDR_RESULT    = 8'hFF;

    // ------------------------------------------------------------
    // reset values and vectors
    // ------------------------------------------------------------
    localparam logic [11:0] CPPS_RESET_VECTOR = 12'hFFE;
    localparam logic [11:0] CPPS_PC_RST       = 12'h000;
    localparam logic [7:0]  CPPS_REG_RST      = 8'h00;
    localparam logic [2:0]  CPPS_DEPTH_RST    = 3'h0;
    localparam logic [2:0]  CPPS_DEPTH_MAX    = 3'h6;
    localparam logic [11:0] CPPS_PC_ONE       = 12'h001;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CPPS_MODE_NORMAL,
        CPPS_MODE_INT,
        CPPS_MODE_NMI
    } cpps_mode_t;

    typedef enum logic [2:0] {
        CPPS_PC_HOLD,
        CPPS_PC_INC,
        CPPS_PC_REL,
        CPPS_PC_JUMP,
        CPPS_PC_CALL,
        CPPS_PC_INT,
        CPPS_PC_NMI,
        CPPS_PC_RET
    } cpps_pc_op_t;

    // ------------------------------------------------------------
    // command carriers
    // ------------------------------------------------------------
    typedef struct packed {
        cpps_pc_op_t  op;
        logic         is_int_exit_op;
        logic [11:0]  target;
        logic [7:0]   offset;
    } cpps_pc_cmd_t;

    typedef struct packed {
        logic         wr;
        logic         bit_op;
        logic [7:0]   addr;
        logic [7:0]   wdata;
    } cpps_data_cmd_t;

    typedef struct packed {
        logic         carry_we;
        logic         carry;
        logic         zero_we;
        logic         zero;
    } cpps_flag_cmd_t;

endpackage

// *** hw/cpps_core_state.sv ***
/*
 * Programmer-visible core state: result, pointer and short-direct
 * registers mapped in data space, page select, 12-bit program counter,
 * three mode flag pairs and the six-level return stack.
 * Assumes the instruction sequencer issues at most one program-counter
 * operation and one data-space access per clock, and computes flag
 * values itself (carry, borrow, tested bit, zero result).
 */
`timescale 1ns/10ps
module cpps_core_state
    import cpps_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    // sequencer commands
    input  wire cpps_pc_cmd_t         pc_cmd_in,
    input  wire logic [11:0]          vector_in,
    input  wire cpps_data_cmd_t       data_cmd_in,
    input  wire cpps_flag_cmd_t       flag_cmd_in,
    // program state
    output logic [11:0]               pc_out,
    output logic [7:0]                result_out,
    output logic [7:0]                ptr_one_out,
    output logic [7:0]                ptr_two_out,
    output logic [7:0]                short_one_out,
    output logic [7:0]                short_two_out,
    output logic [4:0]                page_sel_out,
    // data-space read path
    output logic [7:0]                rdata_out,
    output logic                      hit_out,
    // active flags and mode
    output logic                      carry_out,
    output logic                      zero_out,
    output cpps_mode_t                mode_out,
    output logic [2:0]                depth_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [11:0] pc_q;
    logic [11:0] pc_d;
    logic [7:0]  result_q;
    logic [7:0]  ptr_one_q;
    logic [7:0]  ptr_two_q;
    logic [7:0]  short_one_q;
    logic [7:0]  short_two_q;
    logic [4:0]  page_sel_q;
    cpps_mode_t  mode_q;
    cpps_mode_t  mode_d;
    cpps_mode_t  prev_mode_q;
    logic [1:0]  carry_q;
    logic [1:0]  zero_q;
    logic        normal_carry_flag;
    logic        normal_zero_flag;
    logic        int_carry_flag;
    logic        int_zero_flag;
    logic        nmi_carry_flag;
    logic        nmi_zero_flag;
    logic [11:0] stack_q [CPPS_STACK_N];
    logic [2:0]  depth_q;
    logic        push;
    logic        pop;
    logic        wr;

    function automatic logic is_push(input cpps_pc_op_t op);
        return (op == CPPS_PC_CALL) || (op == CPPS_PC_INT) || (op == CPPS_PC_NMI);
    endfunction

    assign push = is_push(pc_cmd_in.op);
    assign pop  = (pc_cmd_in.op == CPPS_PC_RET);
    // page select may not be written by bit operations
    assign wr   = data_cmd_in.wr;

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_comb begin
        pc_d = pc_q;
        case (pc_cmd_in.op)
            CPPS_PC_INC: pc_d = 12'(pc_q + CPPS_PC_ONE);
            CPPS_PC_REL: pc_d = 12'(pc_q + {{4{pc_cmd_in.offset[7]}}, pc_cmd_in.offset});
            CPPS_PC_JUMP: pc_d = pc_cmd_in.target;
            CPPS_PC_CALL: pc_d = pc_cmd_in.target;
            CPPS_PC_INT:  pc_d = vector_in;
            CPPS_PC_NMI:  pc_d = vector_in;
            CPPS_PC_RET: begin
                // empty stack falls through to next instruction
                if (depth_q == CPPS_DEPTH_RST) begin
                    pc_d = 12'(pc_q + CPPS_PC_ONE);
                end else begin
                    pc_d = stack_q[0];
                end
            end
            default: pc_d = pc_q;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_q <= CPPS_RESET_VECTOR;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    // levels held outside data space
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            // shift down, pc into level one
            for (int i = CPPS_STACK_N - 1; i > 0; i--) begin
                stack_q[i] <= stack_q[i-1];
            end
            stack_q[0] <= pc_q;
        end else if (pop && depth_q != CPPS_DEPTH_RST) begin
            for (int i = 0; i < CPPS_STACK_N - 1; i++) begin
                stack_q[i] <= stack_q[i+1];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            depth_q <= CPPS_DEPTH_RST;
        end else if (push) begin
            if (depth_q != CPPS_DEPTH_MAX) begin
                depth_q <= 3'(depth_q + 3'h1);
            end
        end else if (pop && depth_q != CPPS_DEPTH_RST) begin
            depth_q <= 3'(depth_q - 3'h1);
        end
    end

    // ------------------------------------------------------------
    // execution mode
    // ------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        if (pc_cmd_in.op == CPPS_PC_NMI) begin
            mode_d = CPPS_MODE_NMI;
        end else if (pc_cmd_in.op == CPPS_PC_INT) begin
            mode_d = CPPS_MODE_INT;
        end else if (pop && pc_cmd_in.is_int_exit_op) begin
            mode_d = prev_mode_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q      <= CPPS_MODE_NMI;
            prev_mode_q <= CPPS_MODE_NORMAL;
        end else begin
            mode_q <= mode_d;
            if (pc_cmd_in.op == CPPS_PC_NMI || pc_cmd_in.op == CPPS_PC_INT) begin
                prev_mode_q <= (mode_q == CPPS_MODE_INT) ? CPPS_MODE_INT : CPPS_MODE_NORMAL;
            end else if (pop && pc_cmd_in.is_int_exit_op) begin
                // nesting beyond one level is handled by software discipline
                prev_mode_q <= CPPS_MODE_NORMAL;
            end
        end
    end

    // ------------------------------------------------------------
    // flag pairs
    // ------------------------------------------------------------
    // one pair per mode, index = mode for normal and int, nmi pair held in its own flags
    always_ff @(posedge core_clk_in) begin
        // only the active pair is written
        if (flag_cmd_in.carry_we) begin
            case (mode_q)
                CPPS_MODE_NORMAL: carry_q[0] <= flag_cmd_in.carry;
                CPPS_MODE_INT:    carry_q[1] <= flag_cmd_in.carry;
                default:          nmi_carry_flag <= flag_cmd_in.carry;
            endcase
        end
        if (flag_cmd_in.zero_we) begin
            case (mode_q)
                CPPS_MODE_NORMAL: zero_q[0] <= flag_cmd_in.zero;
                CPPS_MODE_INT:    zero_q[1] <= flag_cmd_in.zero;
                default:          nmi_zero_flag <= flag_cmd_in.zero;
            endcase
        end
    end

    assign normal_carry_flag = carry_q[0];
    assign normal_zero_flag  = zero_q[0];
    assign int_carry_flag    = carry_q[1];
    assign int_zero_flag     = zero_q[1];

    // only the active pair is visible
    always_comb begin
        case (mode_q)
            CPPS_MODE_NORMAL: begin
                carry_out = normal_carry_flag;
                zero_out  = normal_zero_flag;
            end
            CPPS_MODE_INT: begin
                carry_out = int_carry_flag;
                zero_out  = int_zero_flag;
            end
            default: begin
                carry_out = nmi_carry_flag;
                zero_out  = nmi_zero_flag;
            end
        endcase
    end

    // ------------------------------------------------------------
    // data-space registers
    // ------------------------------------------------------------
    // reset to zero so outputs are defined from reset onward
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_q    <= CPPS_REG_RST;
            ptr_one_q   <= CPPS_REG_RST;
            ptr_two_q   <= CPPS_REG_RST;
            short_one_q <= CPPS_REG_RST;
            short_two_q <= CPPS_REG_RST;
        end else if (wr) begin
            if (data_cmd_in.addr == CPPS_ADDR_RESULT) begin
                result_q <= data_cmd_in.wdata;
            end else if (data_cmd_in.addr == CPPS_ADDR_PTR_ONE) begin
                ptr_one_q <= data_cmd_in.wdata;
            end else if (data_cmd_in.addr == CPPS_ADDR_PTR_TWO) begin
                ptr_two_q <= data_cmd_in.wdata;
            end else if (data_cmd_in.addr == CPPS_ADDR_SHORT_ONE) begin
                short_one_q <= data_cmd_in.wdata;
            end else if (data_cmd_in.addr == CPPS_ADDR_SHORT_TWO) begin
                short_two_q <= data_cmd_in.wdata;
            end
        end
    end

    // write-only bank select, bit ops ignored
    // only a data write changes it
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_sel_q <= 5'h00;
        end else if (wr && !data_cmd_in.bit_op && data_cmd_in.addr == CPPS_ADDR_PAGE_SEL) begin
            page_sel_q <= data_cmd_in.wdata[4:0];
        end
    end

    // read mux; page select reads as no hit since it is write-only
    always_comb begin
        hit_out   = 1'b1;
        rdata_out = CPPS_REG_RST;
        if (data_cmd_in.addr == CPPS_ADDR_RESULT) begin
            rdata_out = result_q;
        end else if (data_cmd_in.addr == CPPS_ADDR_PTR_ONE) begin
            rdata_out = ptr_one_q;
        end else if (data_cmd_in.addr == CPPS_ADDR_PTR_TWO) begin
            rdata_out = ptr_two_q;
        end else if (data_cmd_in.addr == CPPS_ADDR_SHORT_ONE) begin
            rdata_out = short_one_q;
        end else if (data_cmd_in.addr == CPPS_ADDR_SHORT_TWO) begin
            rdata_out = short_two_q;
        end else begin
            hit_out = 1'b0;
        end
    end

    assign pc_out        = pc_q;
    assign result_out    = result_q;
    assign ptr_one_out   = ptr_one_q;
    assign ptr_two_out   = ptr_two_q;
    assign short_one_out = short_one_q;
    assign short_two_out = short_two_q;
    assign page_sel_out  = page_sel_q;
    assign mode_out      = mode_q;
    assign depth_out     = depth_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_inc;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pc_cmd_in.op == CPPS_PC_INC |=> pc_q == 12'($past(pc_q) + CPPS_PC_ONE);
    endproperty
    a_inc: assert property (p_inc) else $error("pc did not increment");

    property p_jump;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pc_cmd_in.op == CPPS_PC_JUMP |=> pc_q == $past(pc_cmd_in.target);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not loaded");

    property p_push;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pc_cmd_in.op == CPPS_PC_CALL |=> stack_q[0] == $past(pc_q);
    endproperty
    a_push: assert property (p_push) else $error("call did not stack pc");

    property p_pop;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pop && depth_q != CPPS_DEPTH_RST |=> pc_q == $past(stack_q[0]);
    endproperty
    a_pop: assert property (p_pop) else $error("return did not pop");

    property p_sat;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        depth_q <= CPPS_DEPTH_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("stack depth beyond six");

    property p_empty;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pop && depth_q == CPPS_DEPTH_RST |=> depth_q == CPPS_DEPTH_RST
            && pc_q == 12'($past(pc_q) + CPPS_PC_ONE);
    endproperty
    a_empty: assert property (p_empty) else $error("empty return misbehaved");

    property p_int_mode;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pc_cmd_in.op == CPPS_PC_INT |=> mode_q == CPPS_MODE_INT;
    endproperty
    a_int_mode: assert property (p_int_mode) else $error("no int mode switch");

    property p_keep_page;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        push && !wr |=> $stable(page_sel_q);
    endproperty
    a_keep_page: assert property (p_keep_page) else $error("page select moved");

    property p_flag_keep;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        mode_q == CPPS_MODE_NORMAL && flag_cmd_in.carry_we ##1 mode_q != CPPS_MODE_NORMAL [*2]
            ##1 mode_q == CPPS_MODE_NORMAL && !flag_cmd_in.carry_we
        |-> normal_carry_flag == $past(flag_cmd_in.carry, 3);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("normal carry lost");

endmodule

// *** bench/cpps_core_state_tb_top.sv ***
/*
 * Self-checking bench for the core program-state block: reset state,
 * mapped registers, program-counter sources, mode flag pairs and the
 * six-level return stack.
 * Assumes one-cycle update of all state outputs and combinational
 * data-space read, as the block's hand-over describes.
 */
`timescale 1ns/10ps
module cpps_core_state_tb_top
    import cpps_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic           core_clk_in;
    logic           rst_n_in;
    cpps_pc_cmd_t   pc_cmd_in;
    logic [11:0]    vector_in;
    cpps_data_cmd_t data_cmd_in;
    cpps_flag_cmd_t flag_cmd_in;
    logic [11:0]    pc_out;
    logic [7:0]     result_out;
    logic [7:0]     ptr_one_out;
    logic [7:0]     ptr_two_out;
    logic [7:0]     short_one_out;
    logic [7:0]     short_two_out;
    logic [4:0]     page_sel_out;
    logic [7:0]     rdata_out;
    logic           hit_out;
    logic           carry_out;
    logic           zero_out;
    cpps_mode_t     mode_out;
    logic [2:0]     depth_out;
    int             miscompares = 0;
    int             compares    = 0;

    localparam logic [7:0] REG_ADDR [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); end end

    cpps_core_state u_cpps_core_state (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .pc_cmd_in     (pc_cmd_in),
        .vector_in     (vector_in),
        .data_cmd_in   (data_cmd_in),
        .flag_cmd_in   (flag_cmd_in),
        .pc_out        (pc_out),
        .result_out    (result_out),
        .ptr_one_out   (ptr_one_out),
        .ptr_two_out   (ptr_two_out),
        .short_one_out (short_one_out),
        .short_two_out (short_two_out),
        .page_sel_out  (page_sel_out),
        .rdata_out     (rdata_out),
        .hit_out       (hit_out),
        .carry_out     (carry_out),
        .zero_out      (zero_out),
        .mode_out      (mode_out),
        .depth_out     (depth_out)
    );

    // ------------------------------------------------------------
    // drivers: change inputs 1 ns after the edge, idle edge after each op
    // ------------------------------------------------------------
    initial core_clk_in = 1'b0;
    always #12.5 core_clk_in = ~core_clk_in;

    task automatic step();
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic do_pc(input cpps_pc_op_t op, input logic int_exit_op, input logic [11:0] tgt,
                         input logic [7:0] off);
        pc_cmd_in = '{op: op, is_int_exit_op: int_exit_op, target: tgt, offset: off};
        vector_in = tgt;
        step();
        pc_cmd_in.op = CPPS_PC_HOLD;
        step();
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data, input logic bit_op);
        data_cmd_in = '{wr: 1'b1, bit_op: bit_op, addr: addr, wdata: data};
        step();
        data_cmd_in.wr = 1'b0;
        step();
    endtask

    task automatic set_flags(input logic c, input logic z);
        flag_cmd_in = '{carry_we: 1'b1, carry: c, zero_we: 1'b1, zero: z};
        step();
        flag_cmd_in = '0;
        step();
    endtask

    task automatic chk_flags(input logic c, input logic z, input cpps_mode_t m);
        `CHK(mode_out, m)
        `CHK(carry_out, c)
        `CHK(zero_out, z)
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic chk_reset();
        `CHK(pc_out, 12'hFFE)
        `CHK(mode_out, CPPS_MODE_NMI)
        `CHK(depth_out, 3'h0)
    endtask

    // reset to nmi, out to normal, nested int and nmi, back out
    task automatic chk_modes();
        set_flags(1'b1, 1'b0);
        chk_flags(1'b1, 1'b0, CPPS_MODE_NMI);
        do_pc(CPPS_PC_RET, 1'b1, 12'h000, 8'h00);
        `CHK(pc_out, 12'hFFF)
        `CHK(depth_out, 3'h0)
        `CHK(mode_out, CPPS_MODE_NORMAL)
        set_flags(1'b0, 1'b1);
        do_pc(CPPS_PC_INT, 1'b0, 12'hFF0, 8'h00);
        `CHK(pc_out, 12'hFF0)
        `CHK(mode_out, CPPS_MODE_INT)
        set_flags(1'b1, 1'b1);
        do_pc(CPPS_PC_NMI, 1'b0, 12'hFFC, 8'h00);
        chk_flags(1'b1, 1'b0, CPPS_MODE_NMI);
        `CHK(depth_out, 3'h2)
        do_pc(CPPS_PC_RET, 1'b1, 12'h000, 8'h00);
        chk_flags(1'b1, 1'b1, CPPS_MODE_INT);
        `CHK(pc_out, 12'hFF0)
        do_pc(CPPS_PC_RET, 1'b1, 12'h000, 8'h00);
        chk_flags(1'b0, 1'b1, CPPS_MODE_NORMAL);
        `CHK(pc_out, 12'hFFF)
    endtask

    // flag write and interrupt entry on one edge; normal pair must survive
    task automatic chk_keep();
        flag_cmd_in  = '{carry_we: 1'b1, carry: 1'b1, zero_we: 1'b1, zero: 1'b0};
        pc_cmd_in    = '{op: CPPS_PC_INT, is_int_exit_op: 1'b0, target: 12'h000, offset: 8'h00};
        vector_in    = 12'hFF2;
        step();
        `CHK(pc_out, 12'hFF2)
        flag_cmd_in  = '{carry_we: 1'b1, carry: 1'b0, zero_we: 1'b1, zero: 1'b1};
        pc_cmd_in.op = CPPS_PC_HOLD;
        step();
        chk_flags(1'b0, 1'b1, CPPS_MODE_INT);
        flag_cmd_in  = '0;
        do_pc(CPPS_PC_RET, 1'b1, 12'h000, 8'h00);
        chk_flags(1'b1, 1'b0, CPPS_MODE_NORMAL);
        `CHK(pc_out, 12'hFFF)
    endtask

    task automatic chk_regs();
        for (int i = 0; i < 5; i++) begin
            wr_reg(REG_ADDR[i], 8'hA5 ^ 8'(i * 17), 1'b0);
        end
        for (int i = 0; i < 5; i++) begin
            data_cmd_in.addr = REG_ADDR[i];
            step();
            `CHK(rdata_out, 8'hA5 ^ 8'(i * 17))
            `CHK(hit_out, 1'b1)
        end
        `CHK(ptr_one_out, 8'hA5)
        `CHK(ptr_two_out, 8'hB4)
        `CHK(short_one_out, 8'h87)
        `CHK(short_two_out, 8'h96)
        `CHK(result_out, 8'hE1)
        wr_reg(8'h82, 8'h3C, 1'b1);
        `CHK(short_one_out, 8'h3C)
        wr_reg(8'h81, 8'hC3, 1'b1);
        `CHK(ptr_two_out, 8'hC3)
        // page select takes byte writes only and never reads back
        wr_reg(8'hCA, 8'h5A, 1'b0);
        `CHK(page_sel_out, 5'h1A)
        wr_reg(8'hCA, 8'h07, 1'b1);
        `CHK(page_sel_out, 5'h1A)
        data_cmd_in.addr = 8'hCA;
        step();
        `CHK(hit_out, 1'b0)
        data_cmd_in.addr = 8'h10;
        step();
        `CHK(hit_out, 1'b0)
    endtask

    task automatic chk_pc();
        do_pc(CPPS_PC_JUMP, 1'b0, 12'h7FE, 8'h00);
        `CHK(pc_out, 12'h7FE)
        do_pc(CPPS_PC_INC, 1'b0, 12'h000, 8'h00);
        do_pc(CPPS_PC_INC, 1'b0, 12'h000, 8'h00);
        `CHK(pc_out, 12'h800)
        do_pc(CPPS_PC_REL, 1'b0, 12'h000, 8'h10);
        `CHK(pc_out, 12'h810)
        do_pc(CPPS_PC_REL, 1'b0, 12'h000, 8'hF0);
        `CHK(pc_out, 12'h800)
        do_pc(CPPS_PC_JUMP, 1'b0, 12'hFFF, 8'h00);
        do_pc(CPPS_PC_INC, 1'b0, 12'h000, 8'h00);
        `CHK(pc_out, 12'h000)
    endtask

    // seven calls overflow six levels; the first return address is lost
    task automatic chk_stack();
        for (int i = 0; i < 7; i++) begin
            do_pc(CPPS_PC_CALL, 1'b0, 12'h100 + 12'(i), 8'h00);
            `CHK(depth_out, 3'((i < 6) ? i + 1 : 6))
        end
        for (int i = 0; i < 6; i++) begin
            do_pc(CPPS_PC_RET, 1'b0, 12'h000, 8'h00);
            `CHK(pc_out, 12'h105 - 12'(i))
            `CHK(depth_out, 3'(5 - i))
        end
        do_pc(CPPS_PC_RET, 1'b0, 12'h000, 8'h00);
        `CHK(pc_out, 12'h101)
        `CHK(depth_out, 3'h0)
        `CHK(page_sel_out, 5'h1A)
    endtask

    // reset in mid-run from normal mode with one level stacked
    task automatic chk_rerun();
        do_pc(CPPS_PC_CALL, 1'b0, 12'h234, 8'h00);
        `CHK(depth_out, 3'h1)
        rst_n_in = 1'b0;
        step();
        rst_n_in = 1'b1;
        chk_reset();
    endtask

    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic results();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk_in);
        miscompares++;
        results();
    end

    initial begin
        rst_n_in    = 1'b0;
        pc_cmd_in   = '{op: CPPS_PC_HOLD, is_int_exit_op: 1'b0, target: 12'h000, offset: 8'h00};
        vector_in   = 12'h000;
        data_cmd_in = '0;
        flag_cmd_in = '0;
        repeat (4) @(posedge core_clk_in);
        #1;
        rst_n_in = 1'b1;
        chk_reset();
        chk_modes();
        chk_keep();
        chk_regs();
        chk_pc();
        chk_stack();
        chk_rerun();
        results();
    end
endmodule
